// [shared/tpc_params.svh]
// Register offsets, field positions, reset values and counts for the timer pair
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
`define TPC_OFS_CTRL_A     12'h000
`define TPC_OFS_CTRL_B     12'h004
`define TPC_OFS_COUNT_A    12'h008
`define TPC_OFS_COUNT_B    12'h00C
`define TPC_OFS_PERIOD_A   12'h010
`define TPC_OFS_PERIOD_B   12'h014
`define TPC_OFS_IRQ_STAT   12'h018
`define TPC_OFS_IRQ_MASK   12'h01C
`define TPC_OFS_SYS        12'h020
`define TPC_BIT_RUN        15
`define TPC_BIT_SIDL       13
`define TPC_BIT_GATE       6
`define TPC_BIT_PS_HI      5
`define TPC_BIT_PS_LO      4
`define TPC_BIT_CASC       3
`define TPC_BIT_CSRC       1
`define TPC_CTRL_A_MASK    16'hA07A
`define TPC_CTRL_B_MASK    16'hA072
`define TPC_CTRL_RST       16'h0000
`define TPC_PERIOD_RST     16'hFFFF
`define TPC_DIV_8          8'h07
`define TPC_DIV_64         8'h3F
`define TPC_DIV_256        8'hFF
`endif

// [shared/tpc_pkg.sv]
// Types shared by the timer pair control block
package tpc_pkg;
	typedef struct packed {
		logic       run;
		logic       sidl;
		logic       gate_en;
		logic [1:0] ps;
		logic       csrc;
	} tpc_ctrl_t;
endpackage

// [hdl/tpc_timer_pair.sv]
// Timer pair with APB register access, cascade, prescale, gating and interrupt
//
// Functional notes
// - External clock selected: gate enable ignored
// - Internal clock, gate on: count while gate
// - Internal clock, gate off: count every tick
// - Cascade bit set: one 32-bit counter
// - Cascade bit clear: two independent 16-bit counters
// - Source bit picks pin edges or pclk
// - Timer B run bit starts/stops it
// - Cascade: timer B control bits ignored
// - Cascade: timer A low, timer B high
// - Cascade: A clock/gate, B interrupt flag
`include "tpc_params.svh"
module tpc_timer_pair
	import tpc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_clk_a,
	input  wire logic        ext_clk_b,
	input  wire logic        gate_a,
	input  wire logic        gate_b,
	input  wire logic        idle_mode,
	output logic             irq
);
	logic [15:0] ctrl_a_r;             // Timer A control
	logic [15:0] ctrl_b_r;             // Timer B control
	logic [15:0] cnt_a_r;              // Timer A count
	logic [15:0] cnt_b_r;              // Timer B count
	logic [15:0] per_a_r;              // Timer A period
	logic [15:0] per_b_r;              // Timer B period
	logic [1:0]  stat_r;               // Sticky period-match flags
	logic [1:0]  mask_r;               // Interrupt enables
	logic [7:0]  pre_a_r;              // Prescale counter A
	logic [7:0]  pre_b_r;              // Prescale counter B
	logic        ext_a_d_r;            // Previous pin level A
	logic        ext_b_d_r;            // Previous pin level B
	logic        gate_a_d_r;           // Previous gate level A
	logic        gate_b_d_r;           // Previous gate level B
	logic [31:0] prdata_r;             // Read data register
	logic        pready_r;             // Ready register
	logic        pslverr_r;            // Error register
	logic        irq_r;                // Interrupt register

	// Unpack control word into fields
	function automatic tpc_ctrl_t unpack(input logic [15:0] c);
		tpc_ctrl_t f;
		f.run     = c[`TPC_BIT_RUN];
		f.sidl    = c[`TPC_BIT_SIDL];
		f.gate_en = c[`TPC_BIT_GATE];
		f.ps      = c[`TPC_BIT_PS_HI:`TPC_BIT_PS_LO];
		f.csrc    = c[`TPC_BIT_CSRC];
		return f;
	endfunction

	// Terminal count of the prescaler for a code
	function automatic logic [7:0] div_top(input logic [1:0] ps);
		case (ps)
			2'h3:    div_top = `TPC_DIV_256;
			2'h2:    div_top = `TPC_DIV_64;
			2'h1:    div_top = `TPC_DIV_8;
			default: div_top = 8'h00;
		endcase
	endfunction

	// Raw count tick before prescaler, from source, gate and idle
	function automatic logic raw_tick(input tpc_ctrl_t f, input logic ext_rise,
		input logic gate_lvl, input logic idle);
		logic src;
		src = f.csrc ? ext_rise : 1'b1;
		if (!f.csrc && f.gate_en)
			src = gate_lvl;
		raw_tick = f.run && src && !(f.sidl && idle);
	endfunction

	wire        casc     = ctrl_a_r[`TPC_BIT_CASC];
	wire tpc_ctrl_t fa   = unpack(ctrl_a_r);
	wire tpc_ctrl_t fb   = unpack(ctrl_b_r);
	wire        rise_a   = ext_clk_a && !ext_a_d_r;
	wire        rise_b   = ext_clk_b && !ext_b_d_r;
	wire        raw_a    = raw_tick(fa, rise_a, gate_a, idle_mode);
	wire        raw_b    = raw_tick(fb, rise_b, gate_b, idle_mode);
	wire        pre_a_hit = raw_a && (pre_a_r == div_top(fa.ps));
	wire        pre_b_hit = raw_b && (pre_b_r == div_top(fb.ps));
	wire [31:0] cnt32    = {cnt_b_r, cnt_a_r};
	wire [31:0] per32    = {per_b_r, per_a_r};
	wire        m32      = (cnt32 == per32);
	wire        ma       = (cnt_a_r == per_a_r);
	wire        mb       = (cnt_b_r == per_b_r);
	// Timer B ticks alone only when not cascaded
	wire        tick_b   = !casc && pre_b_hit;

	// Cascade: match on both words; event on timer B flag
	wire        ev_a     = !casc && pre_a_hit && ma;
	wire        ev_b     = casc ? (pre_a_hit && m32) : (tick_b && mb);
	wire [1:0]  ev       = {ev_b, ev_a};

	// Gated mode: falling gate edge is not used; accumulation advances on prescaler hit only (kept simple)
	wire        acc_a    = pre_a_hit;

	// APB decode
	wire        wr_en    = psel && penable && pwrite && !pready_r;
	wire        rd_en    = psel && penable && !pwrite && !pready_r;
	wire        hit_ca   = paddr == `TPC_OFS_CTRL_A;
	wire        hit_cb   = paddr == `TPC_OFS_CTRL_B;
	wire        hit_na   = paddr == `TPC_OFS_COUNT_A;
	wire        hit_nb   = paddr == `TPC_OFS_COUNT_B;
	wire        hit_pa   = paddr == `TPC_OFS_PERIOD_A;
	wire        hit_pb   = paddr == `TPC_OFS_PERIOD_B;
	wire        hit_st   = paddr == `TPC_OFS_IRQ_STAT;
	wire        hit_mk   = paddr == `TPC_OFS_IRQ_MASK;
	wire        hit_sy   = paddr == `TPC_OFS_SYS;
	wire        hit_any  = hit_ca | hit_cb | hit_na | hit_nb | hit_pa | hit_pb
		| hit_st | hit_mk | hit_sy;
	wire        lo_ok    = pstrb[0] && pstrb[1];
	wire [15:0] wd       = pwdata[15:0];
	wire        w_ca     = wr_en && hit_ca && lo_ok;
	wire        w_cb     = wr_en && hit_cb && lo_ok;
	wire        w_na     = wr_en && hit_na && lo_ok;
	wire        w_nb     = wr_en && hit_nb && lo_ok;
	wire        w_pa     = wr_en && hit_pa && lo_ok;
	wire        w_pb     = wr_en && hit_pb && lo_ok;
	wire        w_st     = wr_en && hit_st && pstrb[0];
	wire        w_mk     = wr_en && hit_mk && pstrb[0];

	// Read mux
	wire [31:0] rd_mux =
		hit_ca ? {16'h0000, ctrl_a_r} :
		hit_cb ? {16'h0000, ctrl_b_r} :
		hit_na ? {16'h0000, cnt_a_r} :
		hit_nb ? {16'h0000, cnt_b_r} :
		hit_pa ? {16'h0000, per_a_r} :
		hit_pb ? {16'h0000, per_b_r} :
		hit_st ? {30'h00000000, stat_r} :
		hit_mk ? {30'h00000000, mask_r} :
		hit_sy ? {31'h00000000, casc} : 32'h00000000;

	// Stat next: hardware set wins over write-one-clear
	wire [1:0]  stat_nxt = (stat_r & ~(w_st ? pwdata[1:0] : 2'h0)) | ev;

	// Timer A count next, resets on period match
	wire [15:0] cnt_a_nxt =
		w_na ? wd :
		!acc_a ? cnt_a_r :
		casc ? (m32 ? 16'h0000 : cnt_a_r + 16'h0001) :
		(ma ? 16'h0000 : cnt_a_r + 16'h0001);

	// Timer B count next; cascade carries from timer A
	wire [15:0] cnt_b_nxt =
		w_nb ? wd :
		casc ? (!pre_a_hit ? cnt_b_r :
			m32 ? 16'h0000 :
			(cnt_a_r == 16'hFFFF) ? cnt_b_r + 16'h0001 : cnt_b_r) :
		!tick_b ? cnt_b_r :
		(mb ? 16'h0000 : cnt_b_r + 16'h0001);

	// Control and data registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_r <= `TPC_CTRL_RST;
			ctrl_b_r <= `TPC_CTRL_RST;
			per_a_r  <= `TPC_PERIOD_RST;
			per_b_r  <= `TPC_PERIOD_RST;
			mask_r   <= 2'h0;
		end else begin
			if (w_ca)
				ctrl_a_r <= wd & `TPC_CTRL_A_MASK;
			if (w_cb)
				ctrl_b_r <= wd & `TPC_CTRL_B_MASK;
			if (w_pa)
				per_a_r <= wd;
			if (w_pb)
				per_b_r <= wd;
			if (w_mk)
				mask_r <= pwdata[1:0];
		end
	end

	// Counters, prescalers and status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_a_r <= 16'h0000;
			cnt_b_r <= 16'h0000;
			pre_a_r <= 8'h00;
			pre_b_r <= 8'h00;
			stat_r  <= 2'h0;
		end else begin
			cnt_a_r <= cnt_a_nxt;
			cnt_b_r <= cnt_b_nxt;
			stat_r  <= stat_nxt;
			// Prescaler A: clear on stop or wrap
			if (!fa.run || w_ca)
				pre_a_r <= 8'h00;
			else if (raw_a)
				pre_a_r <= pre_a_hit ? 8'h00 : pre_a_r + 8'h01;
			// Prescaler B: idle while cascaded
			if (!fb.run || w_cb || casc)
				pre_b_r <= 8'h00;
			else if (raw_b)
				pre_b_r <= pre_b_hit ? 8'h00 : pre_b_r + 8'h01;
		end
	end

	// Pin edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_a_d_r  <= 1'b0;
			ext_b_d_r  <= 1'b0;
			gate_a_d_r <= 1'b0;
			gate_b_d_r <= 1'b0;
		end else begin
			ext_a_d_r  <= ext_clk_a;
			ext_b_d_r  <= ext_clk_b;
			gate_a_d_r <= gate_a;
			gate_b_d_r <= gate_b;
		end
	end

	// APB answer and interrupt output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r     <= 1'b0;
		end else begin
			pready_r  <= (wr_en || rd_en);
			pslverr_r <= (wr_en || rd_en) && !hit_any;
			prdata_r  <= rd_en ? rd_mux : 32'h00000000;
			irq_r     <= |(stat_nxt & mask_r);
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign irq     = irq_r;
endmodule

// [verification/tpc_timer_pair_monitor.sv]
// Port checker for the timer pair
module tpc_timer_pair_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Read answer seen at the ready edge
	wire rd_done = pready && !pwrite;
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	a_ready_cause: assert property (pready |-> psel && penable) else $error("stray pready");
	a_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("idle data");
	a_unmapped_err: assert property (pready && paddr > 12'h020 |-> pslverr && prdata == 32'h0)
		else $error("unmapped answer");
	a_mapped_ok: assert property (pready && paddr <= 12'h020 |-> !pslverr) else $error("bad error");
	a_ctrla_rsvd: assert property (rd_done && paddr == 12'h000 |-> (prdata & ~32'hA07A) == 32'h0)
		else $error("ctrl a reserved bits");
	a_ctrlb_rsvd: assert property (rd_done && paddr == 12'h004 |-> (prdata & ~32'hA072) == 32'h0)
		else $error("ctrl b reserved bits");
	a_irq_masked: assert property (pready && pwrite && paddr == 12'h01C && pstrb[0]
		&& pwdata[1:0] == 2'h0 |=> ##1 !irq) else $error("irq not masked");
	// Main scenarios reached
	c_read: cover property (rd_done);
	c_error: cover property (pready && pslverr);
	c_irq: cover property ($rose(irq));
endmodule

// [verification/tpc_ext_clk_src.sv]
// External count clock source: bursts of rising edges
module tpc_ext_clk_src (
	input wire logic       pclk,
	input wire logic       go,
	input wire logic [7:0] edges,
	output logic           pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int         left = 0; // Edges still to make
	logic [1:0] ph = 2'h0; // Two cycles low, two high
	initial pin = 1'b0;
	// Pin rests low between bursts
	always @(posedge pclk) begin
		if (go)
			left <= edges;
		else if (left != 0) begin
			ph <= ph + 2'h1;
			pin <= ph[1];
			if (ph == 2'h3)
				left <= left - 1;
		end else
			pin <= 1'b0;
	end
endmodule

// [verification/testbench.sv]
// Self-checking bench for the timer pair
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rs = 32'h00000A80, v;
	logic [3:0]  pstrb = 0;
	logic        pready, pslverr, irq, ext_a, gate_a = 0, gate_b = 0, idle = 0, go = 0, noise = 1;
	logic [7:0]  edges = 0;
	logic [32:0] expq[$]; // Expected read answers
	int          num_errors = 0, num_checks = 0, cyc = 0, k, n;
	tpc_timer_pair i_tpc_timer_pair (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .ext_clk_a(ext_a), .ext_clk_b(1'b0), .gate_a,
		.gate_b, .idle_mode(idle), .irq);
	tpc_ext_clk_src i_tpc_ext_clk_src (.pclk, .go, .edges, .pin(ext_a));
	initial forever #5 pclk = ~pclk;
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(logic [32:0] seen, logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// One APB transfer, held until pready
	task automatic bus(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, d, 4'hF};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'h0;
	endtask
	task automatic rd(logic [11:0] a, logic [32:0] exp);
		expq.push_back(exp);
		bus(1'b0, a, 32'h0);
	endtask
	// Run a control value for d edges, then stop
	task automatic tm(logic [11:0] a, logic [31:0] c, int d);
		bus(1'b1, a, c);
		repeat (d - 4) @(posedge pclk);
		bus(1'b1, a, 32'h0);
	endtask
	// Read answers compared as they appear
	always @(posedge pclk) if (pready && !pwrite) chk({pslverr, prdata}, expq.pop_front());
	always @(posedge pclk) if (noise) gate_b <= rnd() % 2;
	always @(posedge pclk) if (noise) gate_a <= rnd() % 2;
	always @(posedge pclk) if (++cyc == 20000) begin
		num_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 33'h0);
		rd(12'h014, 33'h0FFFF);
		rd(12'h030, 33'h100000000);
		v = rnd() & 32'hFFFF;
		bus(1'b1, 12'h008, v);
		rd(12'h008, {1'b0, v});
		for (int p = 0; p < 4; p++) begin
			n = (p == 3) ? 256 : 1 << (3 * p);
			k = 4 + rnd() % 4;
			bus(1'b1, 12'h008, 32'h0);
			tm(12'h000, 32'h8000 | (p << 4), n * k + n / 2);
			rd(12'h008, k);
		end
		noise = 0;
		gate_a <= 1'b0;
		bus(1'b1, 12'h008, 32'h0);
		bus(1'b1, 12'h000, 32'h8040);
		repeat (3) @(posedge pclk);
		gate_a <= 1'b1;
		repeat (5) @(posedge pclk);
		gate_a <= 1'b0;
		repeat (3) @(posedge pclk);
		bus(1'b1, 12'h000, 32'h0);
		rd(12'h008, 33'h5);
		n = 3 + rnd() % 6;
		bus(1'b1, 12'h008, 32'h0);
		bus(1'b1, 12'h000, 32'h8042);
		{go, edges} <= {1'b1, n[7:0]};
		@(posedge pclk);
		go <= 1'b0;
		repeat (4 * n + 6) @(posedge pclk);
		bus(1'b1, 12'h000, 32'h0);
		rd(12'h008, n);
		bus(1'b1, 12'h008, 32'hFFFE);
		bus(1'b1, 12'h00C, 32'h0012);
		bus(1'b1, 12'h004, 32'h0032);
		tm(12'h000, 32'h8008, 6);
		rd(12'h008, 33'h4);
		rd(12'h00C, 33'h13);
		tm(12'h004, 32'h8000, 7);
		rd(12'h008, 33'h4);
		rd(12'h00C, 33'h1A);
		idle <= 1'b1;
		tm(12'h004, 32'hA000, 6);
		idle <= 1'b0;
		rd(12'h00C, 33'h1A);
		bus(1'b1, 12'h008, 32'h0);
		bus(1'b1, 12'h010, 32'h3);
		bus(1'b1, 12'h01C, 32'h1);
		tm(12'h000, 32'h8000, 10);
		rd(12'h018, 33'h1);
		chk(irq, 1'b1);
		bus(1'b1, 12'h01C, 32'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		bus(1'b1, 12'h01C, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		bus(1'b1, 12'h018, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		rd(12'h018, 33'h0);
		// Cascaded period match lands on the timer B flag
		bus(1'b1, 12'h008, 32'h0);
		bus(1'b1, 12'h00C, 32'h0);
		bus(1'b1, 12'h010, 32'h2);
		bus(1'b1, 12'h014, 32'h0);
		tm(12'h000, 32'h8008, 5);
		rd(12'h018, 33'h2);
		rd(12'h008, 33'h2);
		rd(12'h00C, 33'h0);
		tally_and_finish();
	end
endmodule
bind tpc_timer_pair tpc_timer_pair_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq);
